/* File: verilog/smr_bank.sv */
/*
 Host register bank and memory window address generator of the scan master.
 Assumes the host strobe has been turned into one-cycle rd_strobe/wr_strobe on ref_clk,
 and a single-port memory of 2K x 32 answers mem_rdata one cycle after mem_addr.
*/
module smr_bank (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [4:0]  addr,
   input  wire logic        rd_strobe,
   input  wire logic        wr_strobe,
   input  wire logic        word_end,
   input  wire logic [15:0] wdata,
   output logic      [15:0] rdata,
   output logic      [10:0] mem_addr,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic      [31:0] mem_wdata,
   input  wire logic [31:0] mem_rdata,
   output logic      [31:0] lfsr_seed,
   input  wire logic [31:0] lfsr_result_in,
   input  wire logic        lfsr_result_load,
   output logic      [2:0]  lfsr_exponent_out,
   output logic      [15:0] scan_start_out,
   output logic      [15:0] config_setup_out,
   output logic      [15:0] tck_divider_out
);
   // window order: scan_out, scan_in, expected, mask, vector, hdr_trl, macro, seq, bridge
   localparam int NWIN = 9;
   localparam logic [10:0] WIN_BASE [NWIN] = '{
      smr_pkg::BASE_SCAN_OUT, smr_pkg::BASE_SCAN_IN, smr_pkg::BASE_EXPECTED,
      smr_pkg::BASE_MASK, smr_pkg::BASE_VECTOR, smr_pkg::BASE_HDR_TRL,
      smr_pkg::BASE_MACRO, smr_pkg::BASE_SEQUENCER, smr_pkg::BASE_BRIDGE};
   localparam logic [10:0] WIN_LAST [NWIN] = '{
      smr_pkg::LAST_BUFFER_INDEX, smr_pkg::LAST_BUFFER_INDEX, smr_pkg::LAST_BUFFER_INDEX,
      smr_pkg::LAST_BUFFER_INDEX, smr_pkg::LAST_VECTOR_INDEX, smr_pkg::LAST_HDR_TRL_INDEX,
      smr_pkg::LAST_MACRO_INDEX, smr_pkg::LAST_SEQUENCER_INDEX, smr_pkg::LAST_BRIDGE_INDEX};
   localparam logic [4:0] WIN_ADDR [NWIN] = '{
      smr_pkg::ADDR_WIN_SCAN_OUT, smr_pkg::ADDR_WIN_SCAN_IN, smr_pkg::ADDR_WIN_EXPECTED,
      smr_pkg::ADDR_WIN_MASK, smr_pkg::ADDR_WIN_VECTOR, smr_pkg::ADDR_WIN_HDR_TRL,
      smr_pkg::ADDR_WIN_MACRO, smr_pkg::ADDR_WIN_SEQUENCER, smr_pkg::ADDR_WIN_BRIDGE};
   localparam logic [4:0] PTR_ADDR [NWIN] = '{
      smr_pkg::ADDR_BUFFER_PTR_LOAD, smr_pkg::ADDR_BUFFER_PTR_LOAD,
      smr_pkg::ADDR_BUFFER_PTR_LOAD, smr_pkg::ADDR_BUFFER_PTR_LOAD,
      smr_pkg::ADDR_VECTOR_POINTER, smr_pkg::ADDR_HDR_TRL_POINTER,
      smr_pkg::ADDR_MACRO_POINTER, smr_pkg::ADDR_SEQUENCER_POINTER,
      smr_pkg::ADDR_BRIDGE_POINTER};

   // registered state
   logic [15:0] scan_start, status_flags, irq_enable, irq_flags;
   logic [15:0] config_setup, tck_divider;
   logic [2:0]  lfsr_exponent;
   logic [15:0] lfsr_seed_low, lfsr_seed_high, lfsr_result_low, lfsr_result_high;
   logic [15:0] buffer_pointer_load, vector_pointer, hdr_trl_pointer;
   logic [15:0] macro_pointer, sequencer_pointer, bridge_pointer;
   logic [15:0] win_low;
   logic [15:0] rdata_q;
   logic [31:0] mem_wdata_q;
   logic        mem_wr_q;
   smr_pkg::smr_half_type half;

   logic [15:0] next_scan_start, next_status_flags, next_irq_enable, next_irq_flags;
   logic [15:0] next_config_setup, next_tck_divider;
   logic [2:0]  next_lfsr_exponent;
   logic [15:0] next_lfsr_seed_low, next_lfsr_seed_high;
   logic [15:0] next_lfsr_result_low, next_lfsr_result_high;
   logic [15:0] next_buffer_pointer_load, next_vector_pointer, next_hdr_trl_pointer;
   logic [15:0] next_macro_pointer, next_sequencer_pointer, next_bridge_pointer;
   logic [15:0] next_win_low;
   logic [15:0] next_rdata;
   logic [31:0] next_mem_wdata;
   logic        next_mem_wr;
   smr_pkg::smr_half_type next_half;

   logic [NWIN-1:0]  win_hit;
   logic [10:0]      ptr_value [NWIN];
   logic [10:0]      win_addr_calc;
   logic             any_win;
   logic             access;

   smr_ptr_if ptr_bus [NWIN] ();

   function automatic logic [10:0] region_addr(input logic [10:0] base,
                                               input logic [10:0] index);
      region_addr = base + index;
   endfunction : region_addr

   assign access = rd_strobe | wr_strobe;

   genvar gi;
   generate
      for (gi = 0; gi < NWIN; gi++) begin : g_win
         smr_pointer #(.LAST(WIN_LAST[gi])) u_ptr (
            .ref_clk (ref_clk),
            .reset   (reset),
            .ptr     (ptr_bus[gi])
         );
         assign win_hit[gi] = (addr == WIN_ADDR[gi]);
         // one pointer load register feeds all four buffer pointers
         assign ptr_bus[gi].load       = wr_strobe && (addr == PTR_ADDR[gi]);
         assign ptr_bus[gi].load_value = wdata[10:0];
         // of the buffers only scan_in steps on reads, the other three on writes; vector and later windows step on either
         if (gi == 1) begin : g_rd
            assign ptr_bus[gi].step = rd_strobe && win_hit[gi] && word_end;
         end else begin : g_wr
            assign ptr_bus[gi].step = access && win_hit[gi] && word_end && (gi > 3 || wr_strobe);
         end
         assign ptr_value[gi] = ptr_bus[gi].value;
      end
   endgenerate

   always_comb begin
      any_win       = 1'b0;
      win_addr_calc = 11'h000;
      for (int i = 0; i < NWIN; i++) begin
         if (win_hit[i]) begin
            any_win       = 1'b1;
            win_addr_calc = region_addr(WIN_BASE[i], ptr_value[i]);
         end
      end
   end

   always_comb begin
      next_scan_start          = scan_start;
      next_status_flags        = status_flags;
      next_irq_enable          = irq_enable;
      next_irq_flags           = irq_flags;
      next_config_setup        = config_setup;
      next_tck_divider         = tck_divider;
      next_lfsr_exponent       = lfsr_exponent;
      next_lfsr_seed_low       = lfsr_seed_low;
      next_lfsr_seed_high      = lfsr_seed_high;
      next_lfsr_result_low     = lfsr_result_low;
      next_lfsr_result_high    = lfsr_result_high;
      next_buffer_pointer_load = buffer_pointer_load;
      next_vector_pointer      = vector_pointer;
      next_hdr_trl_pointer     = hdr_trl_pointer;
      next_macro_pointer       = macro_pointer;
      next_sequencer_pointer   = sequencer_pointer;
      next_bridge_pointer      = bridge_pointer;
      next_win_low             = win_low;
      next_rdata               = rdata_q;
      next_mem_wdata           = mem_wdata_q;
      next_mem_wr              = 1'b0;
      next_half                = half;
      if (lfsr_result_load) begin
         next_lfsr_result_low  = lfsr_result_in[15:0];
         next_lfsr_result_high = lfsr_result_in[31:16];
      end
      if (wr_strobe) begin
         case (addr)
            smr_pkg::ADDR_SCAN_START:        next_scan_start = wdata;
            smr_pkg::ADDR_STATUS_FLAGS:      next_status_flags = wdata;
            smr_pkg::ADDR_IRQ_ENABLE:        next_irq_enable = wdata;
            smr_pkg::ADDR_IRQ_FLAGS:         next_irq_flags = wdata;
            smr_pkg::ADDR_CONFIG_SETUP:      next_config_setup = wdata;
            smr_pkg::ADDR_TCK_DIVIDER:       next_tck_divider = wdata;
            smr_pkg::ADDR_LFSR_EXPONENT:     next_lfsr_exponent = wdata[2:0];
            smr_pkg::ADDR_LFSR_SEED_LOW:     next_lfsr_seed_low = wdata;
            smr_pkg::ADDR_LFSR_SEED_HIGH:    next_lfsr_seed_high = wdata;
            smr_pkg::ADDR_LFSR_RESULT_LOW:   next_lfsr_result_low = wdata;
            smr_pkg::ADDR_LFSR_RESULT_HIGH:  next_lfsr_result_high = wdata;
            smr_pkg::ADDR_BUFFER_PTR_LOAD:   next_buffer_pointer_load = wdata;
            smr_pkg::ADDR_VECTOR_POINTER:    next_vector_pointer = wdata;
            smr_pkg::ADDR_HDR_TRL_POINTER:   next_hdr_trl_pointer = wdata;
            smr_pkg::ADDR_MACRO_POINTER:     next_macro_pointer = wdata;
            smr_pkg::ADDR_SEQUENCER_POINTER: next_sequencer_pointer = wdata;
            smr_pkg::ADDR_BRIDGE_POINTER:    next_bridge_pointer = wdata;
            default: begin
               if (any_win) begin
                  // 16-bit host, so a long word is low half then high half
                  if (!word_end) begin
                     next_win_low = wdata;
                     next_half    = smr_pkg::SMR_HALF_HIGH;
                  end else begin
                     next_mem_wdata = {wdata, win_low};
                     next_mem_wr    = 1'b1;
                     next_half      = smr_pkg::SMR_HALF_LOW;
                  end
               end
               // other addresses write nothing
            end
         endcase
      end
      if (rd_strobe) begin
         case (addr)
            smr_pkg::ADDR_SCAN_START:        next_rdata = scan_start;
            smr_pkg::ADDR_STATUS_FLAGS:      next_rdata = status_flags;
            smr_pkg::ADDR_IRQ_ENABLE:        next_rdata = irq_enable;
            smr_pkg::ADDR_IRQ_FLAGS:         next_rdata = irq_flags;
            smr_pkg::ADDR_CONFIG_SETUP:      next_rdata = config_setup;
            smr_pkg::ADDR_TCK_DIVIDER:       next_rdata = tck_divider;
            smr_pkg::ADDR_LFSR_EXPONENT:     next_rdata = {13'h0000, lfsr_exponent};
            smr_pkg::ADDR_LFSR_SEED_LOW:     next_rdata = lfsr_seed_low;
            smr_pkg::ADDR_LFSR_SEED_HIGH:    next_rdata = lfsr_seed_high;
            smr_pkg::ADDR_LFSR_RESULT_LOW:   next_rdata = lfsr_result_low;
            smr_pkg::ADDR_LFSR_RESULT_HIGH:  next_rdata = lfsr_result_high;
            smr_pkg::ADDR_BUFFER_PTR_LOAD:   next_rdata = buffer_pointer_load;
            smr_pkg::ADDR_VECTOR_POINTER:    next_rdata = vector_pointer;
            smr_pkg::ADDR_HDR_TRL_POINTER:   next_rdata = hdr_trl_pointer;
            smr_pkg::ADDR_MACRO_POINTER:     next_rdata = macro_pointer;
            smr_pkg::ADDR_SEQUENCER_POINTER: next_rdata = sequencer_pointer;
            smr_pkg::ADDR_BRIDGE_POINTER:    next_rdata = bridge_pointer;
            default: begin
               // memory data arrives one cycle late, so window reads take rdata from mem_rdata in the cycle after the strobe
               next_rdata = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scan_start          <= smr_pkg::RESET_ZERO;
         status_flags        <= smr_pkg::RESET_STATUS_FLAGS;
         irq_enable          <= smr_pkg::RESET_ZERO;
         irq_flags           <= smr_pkg::RESET_ZERO;
         config_setup        <= smr_pkg::RESET_CONFIG_SETUP;
         tck_divider         <= smr_pkg::RESET_ZERO;
         lfsr_exponent       <= 3'h0;
         lfsr_seed_low       <= smr_pkg::RESET_ZERO;
         lfsr_seed_high      <= smr_pkg::RESET_ZERO;
         lfsr_result_low     <= smr_pkg::RESET_ZERO;
         lfsr_result_high    <= smr_pkg::RESET_ZERO;
         buffer_pointer_load <= smr_pkg::RESET_ZERO;
         vector_pointer      <= smr_pkg::RESET_ZERO;
         hdr_trl_pointer     <= smr_pkg::RESET_ZERO;
         macro_pointer       <= smr_pkg::RESET_ZERO;
         sequencer_pointer   <= smr_pkg::RESET_ZERO;
         bridge_pointer      <= smr_pkg::RESET_ZERO;
         win_low             <= smr_pkg::RESET_ZERO;
         rdata_q             <= smr_pkg::RESET_ZERO;
         mem_wdata_q         <= 32'h0000_0000;
         mem_wr_q            <= 1'b0;
         half                <= smr_pkg::SMR_HALF_LOW;
      end else begin
         scan_start          <= next_scan_start;
         status_flags        <= next_status_flags;
         irq_enable          <= next_irq_enable;
         irq_flags           <= next_irq_flags;
         config_setup        <= next_config_setup;
         tck_divider         <= next_tck_divider;
         lfsr_exponent       <= next_lfsr_exponent;
         lfsr_seed_low       <= next_lfsr_seed_low;
         lfsr_seed_high      <= next_lfsr_seed_high;
         lfsr_result_low     <= next_lfsr_result_low;
         lfsr_result_high    <= next_lfsr_result_high;
         buffer_pointer_load <= next_buffer_pointer_load;
         vector_pointer      <= next_vector_pointer;
         hdr_trl_pointer     <= next_hdr_trl_pointer;
         macro_pointer       <= next_macro_pointer;
         sequencer_pointer   <= next_sequencer_pointer;
         bridge_pointer      <= next_bridge_pointer;
         win_low             <= next_win_low;
         rdata_q             <= next_rdata;
         mem_wdata_q         <= next_mem_wdata;
         mem_wr_q            <= next_mem_wr;
         half                <= next_half;
      end
   end

   // memory address held for the write issued one cycle later
   logic [10:0] mem_addr_q;
   logic [10:0] next_mem_addr;
   logic        window_read_q;
   logic        next_window_read;
   logic        read_high_q;
   logic        next_read_high;

   always_comb begin
      next_mem_addr    = mem_addr_q;
      next_window_read = access && any_win && rd_strobe;
      next_read_high   = word_end;
      if (access && any_win) begin
         next_mem_addr = win_addr_calc;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mem_addr_q    <= 11'h000;
         window_read_q <= 1'b0;
         read_high_q   <= 1'b0;
      end else begin
         mem_addr_q    <= next_mem_addr;
         window_read_q <= next_window_read;
         read_high_q   <= next_read_high;
      end
   end

   // odd vector words carry only alignment padding in their whole high half, which reads back as zero
   logic vector_pad;
   assign vector_pad = (mem_addr_q >= smr_pkg::BASE_VECTOR) &&
                       (mem_addr_q < smr_pkg::BASE_HDR_TRL) && mem_addr_q[0] && read_high_q;

   // a pending write owns the single port, so the host leaves a gap after a long word
   assign mem_addr  = (access && any_win && !mem_wr_q) ? win_addr_calc : mem_addr_q;
   assign mem_rd    = rd_strobe && any_win;
   assign mem_wr    = mem_wr_q;
   assign mem_wdata = mem_wdata_q;
   assign rdata     = !window_read_q ? rdata_q :
                      vector_pad ? 16'h0000 :
                      read_high_q ? mem_rdata[31:16] : mem_rdata[15:0];

   assign lfsr_seed         = {lfsr_seed_high, lfsr_seed_low};
   assign lfsr_exponent_out = lfsr_exponent;
   assign scan_start_out    = scan_start;
   assign config_setup_out  = config_setup;
   assign tck_divider_out   = tck_divider;
endmodule : smr_bank

/* File: verilog/smr_pkg.sv */
/*
 Constants for the scan master host register bank: register addresses, reset values,
 memory region bases, pointer ranges.
 Assumes a 5-bit host address bus and 16-bit host data.
*/
package smr_pkg;
   localparam logic [4:0]  ADDR_SCAN_START        = 5'h00;
   localparam logic [4:0]  ADDR_STATUS_FLAGS      = 5'h01;
   localparam logic [4:0]  ADDR_IRQ_ENABLE        = 5'h02;
   localparam logic [4:0]  ADDR_IRQ_FLAGS         = 5'h03;
   localparam logic [4:0]  ADDR_CONFIG_SETUP      = 5'h04;
   localparam logic [4:0]  ADDR_TCK_DIVIDER       = 5'h05;
   localparam logic [4:0]  ADDR_LFSR_EXPONENT     = 5'h07;
   localparam logic [4:0]  ADDR_LFSR_SEED_LOW     = 5'h08;
   localparam logic [4:0]  ADDR_LFSR_SEED_HIGH    = 5'h09;
   localparam logic [4:0]  ADDR_LFSR_RESULT_LOW   = 5'h0A;
   localparam logic [4:0]  ADDR_LFSR_RESULT_HIGH  = 5'h0B;
   localparam logic [4:0]  ADDR_BUFFER_PTR_LOAD   = 5'h0C;
   localparam logic [4:0]  ADDR_WIN_SCAN_OUT      = 5'h0D;
   localparam logic [4:0]  ADDR_WIN_SCAN_IN       = 5'h0E;
   localparam logic [4:0]  ADDR_WIN_EXPECTED      = 5'h0F;
   localparam logic [4:0]  ADDR_WIN_MASK          = 5'h10;
   localparam logic [4:0]  ADDR_VECTOR_POINTER    = 5'h11;
   localparam logic [4:0]  ADDR_WIN_VECTOR        = 5'h12;
   localparam logic [4:0]  ADDR_HDR_TRL_POINTER   = 5'h13;
   localparam logic [4:0]  ADDR_WIN_HDR_TRL       = 5'h14;
   localparam logic [4:0]  ADDR_MACRO_POINTER     = 5'h15;
   localparam logic [4:0]  ADDR_WIN_MACRO         = 5'h16;
   localparam logic [4:0]  ADDR_SEQUENCER_POINTER = 5'h17;
   localparam logic [4:0]  ADDR_WIN_SEQUENCER     = 5'h18;
   localparam logic [4:0]  ADDR_BRIDGE_POINTER    = 5'h19;
   localparam logic [4:0]  ADDR_WIN_BRIDGE        = 5'h1A;

   localparam logic [15:0] RESET_ZERO             = 16'h0000;
   localparam logic [15:0] RESET_STATUS_FLAGS     = 16'h0800;
   localparam logic [15:0] RESET_CONFIG_SETUP     = 16'h0043;
   localparam int          EXPONENT_BITS          = 3;

   localparam logic [10:0] BASE_SCAN_OUT          = 11'h000;
   localparam logic [10:0] BASE_SCAN_IN           = 11'h1C0;
   localparam logic [10:0] BASE_EXPECTED          = 11'h380;
   localparam logic [10:0] BASE_MASK              = 11'h540;
   localparam logic [10:0] BASE_VECTOR            = 11'h700;
   localparam logic [10:0] BASE_HDR_TRL           = 11'h708;
   localparam logic [10:0] BASE_MACRO             = 11'h788;
   localparam logic [10:0] BASE_SEQUENCER         = 11'h798;
   localparam logic [10:0] BASE_BRIDGE            = 11'h7B8;

   localparam logic [10:0] LAST_BUFFER_INDEX      = 11'h1BF;
   localparam logic [10:0] LAST_VECTOR_INDEX      = 11'h007;
   localparam logic [10:0] LAST_HDR_TRL_INDEX     = 11'h07F;
   localparam logic [10:0] LAST_MACRO_INDEX       = 11'h00F;
   localparam logic [10:0] LAST_SEQUENCER_INDEX   = 11'h01F;
   localparam logic [10:0] LAST_BRIDGE_INDEX      = 11'h03F;

   typedef enum logic [1:0] {
      SMR_HALF_LOW,
      SMR_HALF_HIGH
   } smr_half_type;
endpackage : smr_pkg

/* File: verilog/smr_ptr_if.sv */
/*
 Carrier between the bank and one region pointer: load, step and current value.
 Assumes single-clock use inside the bank.
*/
interface smr_ptr_if;
   logic        load;
   logic [10:0] load_value;
   logic        step;
   logic [10:0] value;
   modport owner (input load, input load_value, input step, output value);
   modport user  (output load, output load_value, output step, input value);
endinterface : smr_ptr_if

/* File: verilog/smr_pointer.sv */
/*
 One auto-incrementing region pointer; wraps to zero past its last index.
 Assumes load and step come from the same clock domain.
*/
module smr_pointer #(
   parameter logic [10:0] LAST = 11'h1BF
) (
   input  wire logic  ref_clk,
   input  wire logic  reset,
   smr_ptr_if.owner   ptr
);
   logic [10:0] value_q;
   logic [10:0] next_value;

   always_comb begin
      next_value = value_q;
      if (ptr.load) begin
         next_value = (ptr.load_value > LAST) ? 11'h000 : ptr.load_value;
      end else if (ptr.step) begin
         // staying inside the region protects the neighbouring one
         next_value = (value_q == LAST) ? 11'h000 : value_q + 11'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         value_q <= 11'h000;
      end else begin
         value_q <= next_value;
      end
   end

   assign ptr.value = value_q;
endmodule : smr_pointer

/* File: sim/smr_mem_model.sv */
/*
 Single-port memory model on the far side of the bank: 2K x 32, registered read.
 Assumes mem_addr is settled before the clock edge that samples it.
*/
module smr_mem_model (
   input  wire logic        ref_clk,
   input  wire logic [10:0] mem_addr,
   input  wire logic        mem_wr,
   input  wire logic [31:0] mem_wdata,
   output logic      [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [2048];
   // plain always: the bench preloads words behind the bank's back
   always @(posedge ref_clk) begin
      if (mem_wr) mem[mem_addr] <= mem_wdata;
      mem_rdata <= mem[mem_addr];
   end
endmodule : smr_mem_model

/* File: sim/smr_bank_asserts.sv */
/*
 Port checker for the host register bank.
 Assumes it is bound to smr_bank and sees only its ports.
*/
module smr_bank_asserts (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic [4:0]  addr,
   input wire logic        rd_strobe,
   input wire logic        wr_strobe,
   input wire logic        word_end,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic [10:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic [31:0] lfsr_seed,
   input wire logic [2:0]  lfsr_exponent_out,
   input wire logic [15:0] scan_start_out,
   input wire logic [15:0] config_setup_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_wr_high;
      wr_strobe && word_end && addr inside {5'h0D, 5'h0F, 5'h10};
   endsequence
   sequence s_acc(logic [4:0] a);
      (rd_strobe || wr_strobe) && addr == a;
   endsequence
   chk_buf_write: assert property (s_wr_high |=> mem_wr)
      else $error("no memory write after high half");
   chk_wr_single: assert property (mem_wr |-> $past(wr_strobe) && $past(word_end)
      ##1 !mem_wr) else $error("stray or long memory write");
   chk_win_read: assert property (rd_strobe && addr inside {5'h0E, 5'h12} |-> mem_rd)
      else $error("window read did not reach memory");
   chk_out_base: assert property (s_acc(5'h0D) |-> mem_addr <= 11'h1BF)
      else $error("scan out address outside region");
   chk_in_base: assert property (s_acc(5'h0E) |-> mem_addr inside {[11'h1C0:11'h37F]})
      else $error("scan in address outside region");
   chk_vec_base: assert property (s_acc(5'h12) |-> mem_addr inside {[11'h700:11'h707]})
      else $error("vector address outside region");
   chk_bridge_base: assert property (s_acc(5'h1A) |-> mem_addr >= 11'h7B8)
      else $error("bridge address outside region");
   chk_undef_read: assert property (rd_strobe && addr inside {5'h06, [5'h1B:5'h1F]}
      |=> rdata == 16'h0000) else $error("undefined address read nonzero");
   chk_exp_bits: assert property (rd_strobe && addr == 5'h07 |=> rdata[15:3] == 13'h0000)
      else $error("exponent read has extra bits");
   chk_seed_load: assert property (wr_strobe && addr == 5'h08
      |=> lfsr_seed[15:0] == $past(wdata)) else $error("seed low not loaded");
   chk_reset_vals: assert property ($fell(reset) |-> config_setup_out == 16'h0043
      && scan_start_out == 16'h0000 && lfsr_exponent_out == 3'h0)
      else $error("wrong value after reset");
endmodule : smr_bank_asserts

bind smr_bank smr_bank_asserts smr_bank_asserts_i (.ref_clk(ref_clk), .reset(reset),
   .addr(addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .word_end(word_end),
   .wdata(wdata), .rdata(rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
   .lfsr_seed(lfsr_seed), .lfsr_exponent_out(lfsr_exponent_out),
   .scan_start_out(scan_start_out), .config_setup_out(config_setup_out));

/* File: sim/test_scan_master_host_register_map.sv */
/*
 Self-checking bench for the host register bank with a memory model behind it.
 Assumes one-cycle host strobes driven on the falling edge.
*/
module test_scan_master_host_register_map;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk, reset, rd_strobe, wr_strobe, word_end, mem_rd, mem_wr, res_ld;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, s_out, c_out, t_out;
   logic [10:0] mem_addr;
   logic [31:0] mem_wdata, mem_rdata, lfsr_seed, res_in;
   logic [2:0]  x_out;
   int          err_count = 0;
   int          n_checks = 0;
   smr_bank smr_bank_i (.ref_clk(ref_clk), .reset(reset), .addr(addr), .rd_strobe(rd_strobe),
      .wr_strobe(wr_strobe), .word_end(word_end), .wdata(wdata), .rdata(rdata),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .lfsr_seed(lfsr_seed), .lfsr_result_in(res_in),
      .lfsr_result_load(res_ld), .lfsr_exponent_out(x_out), .scan_start_out(s_out),
      .config_setup_out(c_out), .tck_divider_out(t_out));
   smr_mem_model smr_mem_model_i (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic we);
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      word_end = we;
      wr_strobe = 1'b1;
      @(negedge ref_clk);
      wr_strobe = 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic we, output logic [15:0] v);
      @(negedge ref_clk);
      addr = a;
      word_end = we;
      rd_strobe = 1'b1;
      @(negedge ref_clk);
      rd_strobe = 1'b0;
      v = rdata;
   endtask : rd
   task automatic wl(input logic [4:0] a, input logic [31:0] d);
      wr(a, d[15:0], 1'b0);
      wr(a, d[31:16], 1'b1);
   endtask : wl
   task automatic rl(input logic [4:0] a, output logic [31:0] d);
      rd(a, 1'b0, d[15:0]);
      rd(a, 1'b1, d[31:16]);
   endtask : rl
   task automatic t_reset_values();
      logic [4:0]  ra [7] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h07, 5'h0B, 5'h19};
      logic [15:0] rv [7] = '{16'h0, 16'h0800, 16'h0043, 16'h0, 16'h0, 16'h0, 16'h0};
      logic [15:0] v;
      for (int i = 0; i < 7; i++) begin
         rd(ra[i], 1'b0, v);
         chk("reset value", {16'h0, rv[i]}, {16'h0, v});
      end
   endtask : t_reset_values
   task automatic t_lfsr_regs();
      logic [15:0] v;
      wr(5'h07, 16'hFFFF, 1'b0);
      rd(5'h07, 1'b0, v);
      chk("exponent", 32'h0007, {16'h0, v});
      wr(5'h08, 16'h1234, 1'b0);
      wr(5'h09, 16'hABCD, 1'b0);
      chk("seed", 32'hABCD1234, lfsr_seed);
      res_in = 32'h89AB4567;
      res_ld = 1'b1;
      @(negedge ref_clk);
      res_ld = 1'b0;
      rd(5'h0A, 1'b0, v);
      chk("result low", 32'h4567, {16'h0, v});
      rd(5'h0B, 1'b0, v);
      chk("result high", 32'h89AB, {16'h0, v});
   endtask : t_lfsr_regs
   task automatic t_undefined();
      logic [15:0] v;
      wr(5'h06, 16'h5A5A, 1'b0);
      wr(5'h1B, 16'hA5A5, 1'b0);
      rd(5'h06, 1'b0, v);
      chk("undefined read", 32'h0, {16'h0, v});
      rd(5'h1F, 1'b0, v);
      chk("undefined read", 32'h0, {16'h0, v});
      chk("no side effect", 32'h00430000, {c_out, t_out});
   endtask : t_undefined
   task automatic t_buffers();
      logic [31:0] d;
      wr(5'h0C, 16'h0005, 1'b0);
      wl(5'h0D, 32'h11110000);
      wl(5'h0D, 32'h11110001);
      wl(5'h0F, 32'h22220000);
      wl(5'h10, 32'h33330000);
      smr_mem_model_i.mem[11'h1C5] = 32'hCAFE0001;
      smr_mem_model_i.mem[11'h1C6] = 32'hCAFE0002;
      rl(5'h0E, d);
      chk("scan in 0", 32'hCAFE0001, d);
      rl(5'h0E, d);
      chk("scan in 1", 32'hCAFE0002, d);
      chk("scan out 0", 32'h11110000, smr_mem_model_i.mem[11'h005]);
      chk("scan out 1", 32'h11110001, smr_mem_model_i.mem[11'h006]);
      chk("expected", 32'h22220000, smr_mem_model_i.mem[11'h385]);
      chk("mask", 32'h33330000, smr_mem_model_i.mem[11'h545]);
   endtask : t_buffers
   task automatic t_windows();
      logic [31:0] d;
      wr(5'h11, 16'h0003, 1'b0);
      smr_mem_model_i.mem[11'h703] = 32'hFFFFFFFF;
      rl(5'h12, d);
      chk("vector upper bytes", 32'h0000FFFF, d);
      wr(5'h19, 16'h003F, 1'b0);
      wl(5'h1A, 32'h44440000);
      wl(5'h1A, 32'h44440001);
      wr(5'h15, 16'h000F, 1'b0);
      wl(5'h16, 32'h55550000);
      wr(5'h17, 16'h0001, 1'b0);
      wl(5'h18, 32'h66660000);
      wr(5'h13, 16'h007F, 1'b0);
      wl(5'h14, 32'h77770000);
      repeat (2) @(negedge ref_clk);
      chk("macro last", 32'h55550000, smr_mem_model_i.mem[11'h797]);
      chk("sequencer", 32'h66660000, smr_mem_model_i.mem[11'h799]);
      chk("hdr trl last", 32'h77770000, smr_mem_model_i.mem[11'h787]);
      chk("bridge last", 32'h44440000, smr_mem_model_i.mem[11'h7F7]);
      chk("bridge wrap", 32'h44440001, smr_mem_model_i.mem[11'h7B8]);
   endtask : t_windows
   task automatic results();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // whole run is about a hundred cycles; 2000 leaves ample margin
   initial begin
      #100us;
      err_count++;
      results();
   end
   initial begin
      reset = 1'b1;
      {rd_strobe, wr_strobe, word_end, res_ld} = 4'h0;
      addr = 5'h00;
      wdata = 16'h0000;
      res_in = 32'h00000000;
      repeat (6) @(negedge ref_clk);
      reset = 1'b0;
      t_reset_values();
      t_lfsr_regs();
      t_undefined();
      t_buffers();
      t_windows();
      results();
   end
endmodule : test_scan_master_host_register_map
